// ===== hdl/tdmc_pkg.sv
// Shared constants, enumerations and carriers of the front-panel controller.
// Assumes a 10 MHz system clock and millisecond timing throughout.
package tdmc_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_US = 1000;                 // Tick period in us
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    localparam int LONG_MS = 1000;                 // Short/long boundary
    localparam int XLONG_MS = 5000;                // Extra-long touch
    localparam int IDLE_MS = 60000;                // Menu inactivity
    localparam int WEL_MS = 5000;                  // Welcome period
    localparam int CAL_MS = 5000;                  // Sensor calibration
    localparam int LED_PULSE_MS = 20;              // Test pulse width
    localparam logic [17:0] MS_PER_S = 18'h003E8;

    // ****************************************************************
    // Screens, digits and thresholds
    // ****************************************************************
    localparam int NUM_C = 8;
    localparam int NUM_CTR = 12;
    localparam int NUM_SCR = 21;
    localparam logic [4:0] SCR_C_FIRST = 5'h04;
    localparam logic [4:0] SCR_MEAS_FIRST = 5'h0C;
    localparam logic [4:0] SCR_P = 5'h0C;
    localparam logic [4:0] SCR_Q = 5'h0D;
    localparam logic [4:0] SCR_S = 5'h0E;
    localparam logic [4:0] SCR_U = 5'h0F;
    localparam logic [4:0] SCR_I = 5'h10;
    localparam logic [4:0] SCR_F = 5'h11;
    localparam logic [4:0] SCR_ANG = 5'h14;
    localparam logic [4:0] SCR_LAST = 5'h14;
    localparam logic [2:0] INT_DIGITS = 3'h6;
    localparam logic [2:0] DEC_NORM = 3'h1;
    localparam logic [2:0] DEC_TEST = 3'h3;
    localparam logic [15:0] NOLOAD_MA = 16'h0014;  // 0.02 A in mA
    localparam logic [1:0] NV_HOLD_ADDR = 2'h0;
    localparam int NV_EN_BIT = 7;
    localparam logic [7:0] NV_RESET_VAL = 8'h00;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum {ST_WELCOME, ST_CYCLE, ST_HOLD, ST_MENU} tdmc_state_t;
    typedef enum logic [2:0] {VIEW_SEG, VIEW_VER, VIEW_CHK, VIEW_MEAS,
        VIEW_MENU, VIEW_SUB} tdmc_view_t;
    typedef enum logic [1:0] {MI_MEASURE, MI_RESET, MI_HOLD,
        MI_INFO} tdmc_item_t;
    typedef enum logic [1:0] {KIND_ACT, KIND_REACT, KIND_APP,
        KIND_NONE} tdmc_kind_t;
    typedef enum logic [3:0] {UNIT_NONE, UNIT_KWH, UNIT_KVARH, UNIT_KVAH,
        UNIT_W, UNIT_VAR, UNIT_VA, UNIT_V, UNIT_A, UNIT_HZ,
        UNIT_DEG} tdmc_unit_t;

    typedef struct packed {
        logic [NUM_CTR-1:0] export_dir;   // Counter counts export energy
        logic [NUM_CTR-1:0] active;       // Counter is accumulating now
        logic [2*NUM_CTR-1:0] kind;       // tdmc_kind_t per counter
    } tdmc_ctr_info_t;

    typedef struct packed {
        tdmc_view_t view;
        logic [4:0] screen;
        tdmc_item_t item;
        logic blink;
        logic lock;
        logic export_dir;
        logic active;
        tdmc_unit_t unit;
        logic hires;
        logic [2:0] int_digits;
        logic [2:0] dec_digits;
    } tdmc_disp_t;

    localparam tdmc_disp_t DISP_RESET = '{VIEW_SEG, 5'h00, MI_MEASURE,
        1'b0, 1'b0, 1'b0, 1'b0, UNIT_NONE, 1'b0, INT_DIGITS, DEC_NORM};

endpackage

// ===== hdl/tdmc_nvmem.sv
// Small retained store holding the locked measurement screen.
// Assumes the array keeps its content across rst; only the read
// register is cleared.
`timescale 1ns/1ps
module tdmc_nvmem
    import tdmc_pkg::*;
(
    input wire logic sys_clk,        // System clock
    input wire logic rst,            // Synchronous reset, high
    input wire logic ce,             // Clock enable
    input wire logic we,             // Write strobe
    input wire logic [1:0] waddr,    // Write address
    input wire logic [7:0] wdata,    // Write data
    input wire logic [1:0] raddr,    // Read address
    output logic [7:0] rdata         // Registered read data
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [7:0] mem [0:3];
    logic [7:0] rdata_next;

    // Array starts blank once, then is never cleared by reset
    initial begin
        for (int i = 0; i < 4; i++) begin
            mem[i] = NV_RESET_VAL;
        end
    end

    // Write port
    always_ff @(posedge sys_clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read register
    always_comb begin
        rdata_next = mem[raddr];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata <= NV_RESET_VAL;
        end else if (ce) begin
            rdata <= rdata_next;
        end
    end

endmodule // tdmc_nvmem

// ===== hdl/tdmc_top.sv
// Front-panel controller: touch classing, welcome, cycling, menu, hold
// page, LED and counter display indicators.
// Assumes touch and all control inputs are synchronous to sys_clk.
`timescale 1ns/1ps
module tdmc_top
    import tdmc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,   // Clocks per ms tick
    parameter int CAL_TICKS = CAL_MS,       // Calibration length, ms
    parameter int XLONG_TICKS = XLONG_MS,   // Extra-long touch, ms
    parameter int IDLE_TICKS = IDLE_MS,     // Inactivity timeout, ms
    parameter int WEL_TICKS = WEL_MS        // Welcome period, ms
) (
    input wire logic sys_clk,               // System clock, 10 MHz
    input wire logic rst,                   // Synchronous reset, high
    input wire logic ce,                    // Clock enable
    input wire logic touch,                 // Sensor touched, high
    input wire logic [15:0] current_ma,     // Measured current, mA
    input wire logic act_wh_pulse,          // One per Wh active
    input wire logic react_varh_pulse,      // One per varh reactive
    input wire logic led_reactive,          // LED follows reactive
    input wire logic test_mode_set,         // Enter test mode
    input wire logic test_mode_clr,         // Leave test mode
    input wire logic [NUM_SCR-1:0] screen_en, // Screens in cycle
    input wire logic [7:0] cycle_period_s,  // Screen period, s
    input wire tdmc_ctr_info_t ctr_info,    // Counter indicators
    output tdmc_disp_t disp,                // Display content
    output logic led,                       // Front LED
    output logic [NUM_C-1:0] ctr_clr,       // Counter clear pulses
    output logic cal_busy                   // Calibration running
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [4:0] next_scr(input logic [4:0] cur,
                                            input logic [NUM_SCR-1:0] m);
        logic [4:0] res;
        logic found;
        int idx;
        res = cur;
        found = 1'b0;
        idx = 0;
        for (int k = 1; k <= NUM_SCR; k++) begin
            idx = (int'(cur) + k) % NUM_SCR;
            if (!found && m[idx]) begin
                res = 5'(idx);
                found = 1'b1;
            end
        end
        return res;
    endfunction

    // ****************************************************************
    // Millisecond tick
    // ****************************************************************
    logic [13:0] tick_cnt_reg, tick_cnt_next;
    logic tick_reg, tick_next;

    // Divide the system clock down to 1 ms
    always_comb begin
        tick_next = 1'b0;
        tick_cnt_next = tick_cnt_reg + 14'h0001;
        if (tick_cnt_reg == 14'(TICK_CYCLES - 1)) begin
            tick_cnt_next = 14'h0000;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tick_cnt_reg <= 14'h0000;
            tick_reg <= 1'b0;
        end else if (ce) begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
        end
    end

    // ****************************************************************
    // Touch calibration and press classing
    // ****************************************************************
    logic [15:0] cal_ms_reg, cal_ms_next;
    logic cal_done_reg, cal_done_next;
    logic [15:0] press_ms_reg, press_ms_next;
    logic held_reg, held_next;
    logic xl_reg, xl_next;
    logic touch_ok, short_ev, long_ev, xl_ev, blink_now;

    // Calibration restarts on any touch; then time presses
    always_comb begin
        cal_ms_next = cal_ms_reg;
        cal_done_next = cal_done_reg;
        if (!cal_done_reg) begin
            if (touch) begin
                cal_ms_next = 16'h0000;
            end else if (tick_reg) begin
                if (cal_ms_reg == 16'(CAL_TICKS - 1)) begin
                    cal_done_next = 1'b1;
                end else begin
                    cal_ms_next = cal_ms_reg + 16'h0001;
                end
            end
        end
        touch_ok = touch && cal_done_reg;
        held_next = touch_ok;
        press_ms_next = 16'h0000;
        if (touch_ok) begin
            press_ms_next = press_ms_reg;
            if (tick_reg && press_ms_reg < 16'(XLONG_TICKS)) begin
                press_ms_next = press_ms_reg + 16'h0001;
            end
        end
        short_ev = held_reg && !touch_ok && !xl_reg
            && press_ms_reg < 16'(LONG_MS);
        long_ev = held_reg && !touch_ok && !xl_reg
            && press_ms_reg >= 16'(LONG_MS);
        xl_ev = touch_ok && !xl_reg
            && press_ms_reg >= 16'(XLONG_TICKS);
        xl_next = touch_ok && (xl_reg || xl_ev);
        blink_now = touch_ok && !xl_reg
            && press_ms_reg >= 16'(LONG_MS);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cal_ms_reg <= 16'h0000;
            cal_done_reg <= 1'b0;
            press_ms_reg <= 16'h0000;
            held_reg <= 1'b0;
            xl_reg <= 1'b0;
        end else if (ce) begin
            cal_ms_reg <= cal_ms_next;
            cal_done_reg <= cal_done_next;
            press_ms_reg <= press_ms_next;
            held_reg <= held_next;
            xl_reg <= xl_next;
        end
    end

    // ****************************************************************
    // Retained hold page
    // ****************************************************************
    logic nv_we_reg, nv_we_next;
    logic [7:0] nv_wdata_reg, nv_wdata_next;
    logic [7:0] nv_rdata;
    logic hold_en;
    logic [4:0] hold_scr;

    tdmc_nvmem u_nvmem (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .we(nv_we_reg),
        .waddr(NV_HOLD_ADDR),
        .wdata(nv_wdata_reg),
        .raddr(NV_HOLD_ADDR),
        .rdata(nv_rdata)
    );

    // Hold setting comes back from the store after every reset
    assign hold_en = nv_rdata[NV_EN_BIT];
    assign hold_scr = nv_rdata[4:0];

    // ****************************************************************
    // Screen and menu sequencing
    // ****************************************************************
    tdmc_state_t state_reg, state_next, base_state;
    logic [4:0] screen_reg, screen_next, resume_scr;
    tdmc_item_t item_reg, item_next;
    logic depth_reg, depth_next;
    logic [17:0] ui_ms_reg, ui_ms_next, period_ms;
    logic test_reg, test_next;
    logic [NUM_C-1:0] ctr_clr_reg, ctr_clr_next, clr_hit;

    // One decode per resettable counter; fixed counters have none
    genvar gi;
    generate
        for (gi = 0; gi < NUM_C; gi++) begin : g_clr
            assign clr_hit[gi] = (screen_reg
                == SCR_C_FIRST + 5'(gi));
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        screen_next = screen_reg;
        item_next = item_reg;
        depth_next = depth_reg;
        test_next = test_reg;
        ctr_clr_next = '0;
        nv_we_next = 1'b0;
        nv_wdata_next = nv_wdata_reg;
        base_state = hold_en ? ST_HOLD : ST_CYCLE;
        resume_scr = hold_en ? hold_scr : screen_reg;
        period_ms = (cycle_period_s == 8'h00) ? MS_PER_S
            : 18'(cycle_period_s) * MS_PER_S;
        ui_ms_next = ui_ms_reg;
        if (tick_reg && ui_ms_reg != '1) begin
            ui_ms_next = ui_ms_reg + 18'h00001;
        end
        if (touch_ok) begin
            ui_ms_next = 18'h00000;
        end
        if (test_mode_clr) begin
            test_next = 1'b0;
        end
        if (test_mode_set) begin
            test_next = 1'b1;
        end
        case (state_reg)
            ST_WELCOME: begin
                if (ui_ms_reg >= 18'(WEL_TICKS)) begin
                    state_next = base_state;
                    screen_next = hold_en ? hold_scr
                        : next_scr(SCR_LAST, screen_en);
                    ui_ms_next = 18'h00000;
                end
            end
            ST_CYCLE, ST_HOLD: begin
                if (long_ev) begin
                    state_next = ST_MENU;
                    item_next = MI_MEASURE;
                    depth_next = 1'b0;
                end else if (short_ev) begin
                    screen_next = next_scr(screen_reg, screen_en);
                end else if (state_reg == ST_CYCLE
                    && ui_ms_reg >= period_ms) begin
                    screen_next = next_scr(screen_reg, screen_en);
                    ui_ms_next = 18'h00000;
                end else if (state_reg == ST_HOLD
                    && ui_ms_reg > 18'(IDLE_TICKS)) begin
                    screen_next = hold_scr;
                end
                if (!long_ev) begin
                    state_next = base_state;
                end
            end
            ST_MENU: begin
                if (xl_ev || ui_ms_reg > 18'(IDLE_TICKS)) begin
                    state_next = base_state;
                    screen_next = resume_scr;
                    depth_next = 1'b0;
                    ui_ms_next = 18'h00000;
                end else if (short_ev) begin
                    if (!depth_reg) begin
                        item_next = tdmc_item_t'(item_reg + 2'h1);
                    end else begin
                        screen_next = next_scr(screen_reg, '1);
                    end
                end else if (long_ev && !depth_reg) begin
                    depth_next = 1'b1;
                end else if (long_ev) begin
                    depth_next = 1'b0;
                    case (item_reg)
                        MI_RESET: begin
                            ctr_clr_next = clr_hit;
                        end
                        MI_HOLD: begin
                            nv_we_next = 1'b1;
                            nv_wdata_next = (hold_en
                                && hold_scr == screen_reg) ? NV_RESET_VAL
                                : {1'b1, 2'h0, screen_reg};
                        end
                        default: begin
                            state_next = base_state;
                            ui_ms_next = 18'h00000;
                        end
                    endcase
                end
            end
            default: begin
                state_next = ST_WELCOME;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_WELCOME;
            screen_reg <= 5'h00;
            item_reg <= MI_MEASURE;
            depth_reg <= 1'b0;
            ui_ms_reg <= 18'h00000;
            test_reg <= 1'b0;
            ctr_clr_reg <= '0;
            nv_we_reg <= 1'b0;
            nv_wdata_reg <= NV_RESET_VAL;
        end else if (ce) begin
            state_reg <= state_next;
            screen_reg <= screen_next;
            item_reg <= item_next;
            depth_reg <= depth_next;
            ui_ms_reg <= ui_ms_next;
            test_reg <= test_next;
            ctr_clr_reg <= ctr_clr_next;
            nv_we_reg <= nv_we_next;
            nv_wdata_reg <= nv_wdata_next;
        end
    end

    // ****************************************************************
    // Front LED
    // ****************************************************************
    logic [5:0] led_ms_reg, led_ms_next;
    logic led_reg, led_next, pulse_in;

    // Steady for no-load, stretched pulse per unit of energy
    always_comb begin
        pulse_in = led_reactive ? react_varh_pulse
            : act_wh_pulse;
        led_ms_next = led_ms_reg;
        if (pulse_in) begin
            led_ms_next = 6'(LED_PULSE_MS);
        end else if (tick_reg && led_ms_reg != 6'h00) begin
            led_ms_next = led_ms_reg - 6'h01;
        end
        led_next = (current_ma < NOLOAD_MA)
            || (led_ms_reg != 6'h00);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            led_ms_reg <= 6'h00;
            led_reg <= 1'b0;
        end else if (ce) begin
            led_ms_reg <= led_ms_next;
            led_reg <= led_next;
        end
    end

    // ****************************************************************
    // Display content
    // ****************************************************************
    tdmc_disp_t disp_reg, disp_next;
    logic cal_busy_reg;
    logic [3:0] ci;

    always_comb begin
        ci = 4'(screen_reg);
        disp_next = DISP_RESET;
        disp_next.screen = screen_reg;
        disp_next.item = item_reg;
        disp_next.blink = blink_now;
        disp_next.hires = test_reg;
        disp_next.int_digits = INT_DIGITS;
        disp_next.dec_digits = test_reg ? DEC_TEST : DEC_NORM;
        if (screen_reg < SCR_MEAS_FIRST) begin
            disp_next.lock = screen_reg < SCR_C_FIRST;
            disp_next.export_dir = ctr_info.export_dir[ci];
            disp_next.active = ctr_info.active[ci];
            case (tdmc_kind_t'(ctr_info.kind[2*ci +: 2]))
                KIND_ACT: disp_next.unit = UNIT_KWH;
                KIND_REACT: disp_next.unit = UNIT_KVARH;
                KIND_APP: disp_next.unit = UNIT_KVAH;
                default: disp_next.unit = UNIT_NONE;
            endcase
        end else begin
            case (screen_reg)
                SCR_P: disp_next.unit = UNIT_W;
                SCR_Q: disp_next.unit = UNIT_VAR;
                SCR_S: disp_next.unit = UNIT_VA;
                SCR_U: disp_next.unit = UNIT_V;
                SCR_I: disp_next.unit = UNIT_A;
                SCR_F: disp_next.unit = UNIT_HZ;
                SCR_ANG: disp_next.unit = UNIT_DEG;
                default: disp_next.unit = UNIT_NONE;
            endcase
        end
        case (state_reg)
            ST_WELCOME: begin
                // Thirds of the welcome period, all marks on first
                if (ui_ms_reg < 18'(WEL_TICKS / 3)) begin
                    disp_next.view = VIEW_SEG;
                    disp_next.lock = 1'b1;
                    disp_next.export_dir = 1'b1;
                    disp_next.active = 1'b1;
                end else if (ui_ms_reg < 18'(2 * WEL_TICKS / 3)) begin
                    disp_next.view = VIEW_VER;
                end else begin
                    disp_next.view = VIEW_CHK;
                end
            end
            ST_MENU: disp_next.view = depth_reg ? VIEW_SUB : VIEW_MENU;
            default: disp_next.view = VIEW_MEAS;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            disp_reg <= DISP_RESET;
            cal_busy_reg <= 1'b1;
        end else if (ce) begin
            disp_reg <= disp_next;
            cal_busy_reg <= !cal_done_next;
        end
    end

    assign disp = disp_reg;
    assign led = led_reg;
    assign ctr_clr = ctr_clr_reg;
    assign cal_busy = cal_busy_reg;

endmodule // tdmc_top

// ===== test/tdmc_finger.sv
// Model of a person touching the capacitive button.
// Assumes callers enter press just after a rising clock edge.
`timescale 1ns/1ps
module tdmc_finger (
    input wire logic sys_clk, // System clock
    output logic touch        // Button touched, high
);
    initial touch = 1'b0;
    // Hold the button a number of clocks, then let go
    task press(input int cyc);
        touch = 1'b1;
        repeat (cyc) @(posedge sys_clk);
        #1;
        touch = 1'b0;
    endtask
endmodule // tdmc_finger

// ===== test/tdmc_properties.sv
// Port checker of the front-panel controller, bound into tdmc_top.
// Assumes properties pause while rst is high or ce is low.
`timescale 1ns/1ps
module tdmc_properties
    import tdmc_pkg::*;
(
    input wire logic sys_clk,             // System clock
    input wire logic rst,                 // Synchronous reset
    input wire logic ce,                  // Clock enable
    input wire logic touch,               // Button touched
    input wire logic [15:0] current_ma,   // Current, mA
    input wire logic act_wh_pulse,        // Active energy pulse
    input wire logic led_reactive,        // LED source select
    input wire tdmc_disp_t disp,          // Display content
    input wire logic led,                 // Front LED
    input wire logic [NUM_C-1:0] ctr_clr, // Counter clears
    input wire logic cal_busy             // Calibrating
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst || !ce);
    property p_noload; current_ma < NOLOAD_MA |=> led; endproperty
    a_noload: assert property (p_noload) else $error("LED dark at no load");
    property p_pulse; act_wh_pulse && !led_reactive |-> ##2 led [*6]; endproperty
    a_pulse: assert property (p_pulse) else $error("test pulse missing");
    property p_cal; cal_busy && touch |=> cal_busy; endproperty
    a_cal: assert property (p_cal) else $error("calibration ended on touch");
    property p_calstay; !cal_busy |=> !cal_busy; endproperty
    a_calstay: assert property (p_calstay) else $error("calibration rerun");
    property p_blink; disp.blink |-> $past(touch, 2); endproperty
    a_blink: assert property (p_blink) else $error("blink without touch");
    property p_onehot; $onehot0(ctr_clr); endproperty
    a_onehot: assert property (p_onehot) else $error("several clears");
    property p_clrpulse; |ctr_clr |=> ctr_clr == '0; endproperty
    a_clrpulse: assert property (p_clrpulse) else $error("clear too long");
    property p_int; disp.int_digits == INT_DIGITS; endproperty
    a_int: assert property (p_int) else $error("integer digits wrong");
    property p_dec; !disp.hires |-> disp.dec_digits == DEC_NORM; endproperty
    a_dec: assert property (p_dec) else $error("decimal digits wrong");
    // Main scenarios reached
    c_clr: cover property (|ctr_clr);
    c_blink: cover property (disp.blink);
    c_sub: cover property (disp.view == VIEW_SUB);
endmodule // tdmc_properties
bind tdmc_top tdmc_properties u_props (.sys_clk(sys_clk), .rst(rst), .ce(ce),
    .touch(touch), .current_ma(current_ma), .act_wh_pulse(act_wh_pulse),
    .led_reactive(led_reactive), .disp(disp), .led(led),
    .ctr_clr(ctr_clr), .cal_busy(cal_busy));

// ===== test/tdmc_tb.sv
// Self-checking bench of the front-panel controller.
// Assumes shortened timing: 2 clocks per ms tick.
`timescale 1ns/1ps
module tdmc_tb;
    import tdmc_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, lr = 1'b0, tms = 1'b0;
    logic act = 1'b0, react = 1'b0, touch, led, cal_busy;
    logic [15:0] cur = 16'h0064;
    logic ce = 1'b1, tmc = 1'b0;
    logic [NUM_SCR-1:0] sen = 21'h000024;
    logic [7:0] per = 8'h01;
    tdmc_ctr_info_t info = '{12'h004, 12'h004, 24'h000010};
    logic [NUM_C-1:0] ctr_clr, clr_seen = '0;
    tdmc_disp_t disp;
    int miscompares = 0, comparisons = 0, i;
    tdmc_finger F (.sys_clk(sys_clk), .touch(touch));
    tdmc_top #(.TICK_CYCLES(2), .CAL_TICKS(20), .XLONG_TICKS(1500),
        .IDLE_TICKS(1600), .WEL_TICKS(21)) DUT (.sys_clk(sys_clk),
        .rst(rst), .ce(ce), .touch(touch), .current_ma(cur),
        .act_wh_pulse(act), .react_varh_pulse(react), .led_reactive(lr),
        .test_mode_set(tms), .test_mode_clr(tmc), .screen_en(sen),
        .cycle_period_s(per), .ctr_info(info), .disp(disp), .led(led),
        .ctr_clr(ctr_clr), .cal_busy(cal_busy));
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (ctr_clr !== '0) clr_seen <= ctr_clr;
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %0t seen %0h expected %0h", $time, s, e);
        end
    endtask
    // Wait whole ms ticks, land just after an edge
    task tk(input int n);
        repeat (2 * n) @(posedge sys_clk);
        #1;
    endtask
    task conclude;
        if (miscompares == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task t_welcome;
        tk(3);
        chk(disp.view, VIEW_SEG);
        F.press(1);
        tk(6);
        chk(disp.view, VIEW_VER);
        tk(7);
        chk(disp.view, VIEW_CHK);
        tk(5);
        chk(cal_busy, 1'b1);
        for (i = 0; i < 40 && cal_busy !== 1'b0; i++) tk(1);
        chk(cal_busy, 1'b0);
        chk(disp.view, VIEW_MEAS);
        chk(disp.screen, 5'h02);
        chk(disp.lock, 1'b1);
        chk(disp.active, 1'b1);
        chk(disp.unit, UNIT_KVARH);
    endtask
    task t_cycle;
        per = 8'h02;
        tk(1000);
        chk(disp.screen, 5'h02);
        tk(1000);
        chk(disp.screen, 5'h05);
        chk(disp.lock, 1'b0);
        chk(disp.unit, UNIT_KWH);
        F.press(4);
        tk(1);
        chk(disp.screen, 5'h02);
    endtask
    task t_menu;
        fork
            F.press(2400);
            begin tk(1100); chk(disp.blink, 1'b1); end
        join
        tk(1);
        chk(disp.view, VIEW_MENU);
        F.press(4);
        tk(1);
        chk(disp.item, MI_RESET);
        F.press(2400);
        tk(1);
        chk(disp.view, VIEW_SUB);
        for (i = 0; i < 21 && disp.screen !== SCR_C_FIRST; i++) begin
            F.press(4);
            tk(1);
        end
        F.press(2400);
        tk(1);
        chk(clr_seen, 8'h01);
        chk(disp.view, VIEW_MENU);
        tk(1700);
        chk(disp.view, VIEW_MEAS);
    endtask
    task t_xlong;
        F.press(2400);
        tk(1);
        chk(disp.view, VIEW_MENU);
        F.press(4);
        tk(1);
        F.press(4);
        tk(1);
        F.press(2400);
        tk(1);
        F.press(2400);
        tk(1);
        fork
            F.press(3400);
            begin tk(1600); chk(disp.view, VIEW_MEAS); end
        join
        tk(1);
        chk(disp.view, VIEW_MEAS);
        chk(disp.screen, 5'h04);
        F.press(4);
        tk(1);
        chk(disp.screen, 5'h05);
        tk(1700);
        chk(disp.screen, 5'h04);
    endtask
    task t_led_test;
        cur = 16'h0014;
        tk(1);
        chk(led, 1'b0);
        ce = 1'b0;
        cur = 16'h0013;
        tk(1);
        chk(led, 1'b0);
        ce = 1'b1;
        tk(1);
        chk(led, 1'b1);
        cur = 16'h0064;
        react = 1'b1;
        tk(1);
        react = 1'b0;
        chk(led, 1'b0);
        act = 1'b1;
        tk(1);
        act = 1'b0;
        chk(led, 1'b1);
        tms = 1'b1;
        tk(1);
        tms = 1'b0;
        chk(disp.hires, 1'b1);
        tmc = 1'b1;
        tk(1);
        chk(disp.hires, 1'b0);
        tms = 1'b1;
        tk(1);
        tms = 1'b0;
        tmc = 1'b0;
        chk(disp.hires, 1'b1);
        tk(21);
        chk(led, 1'b0);
        lr = 1'b1;
        react = 1'b1;
        tk(1);
        react = 1'b0;
        chk(led, 1'b1);
        rst = 1'b1;
        tk(2);
        rst = 1'b0;
        tk(1);
        chk(disp.hires, 1'b0);
        tk(30);
        chk(disp.screen, 5'h04);
    endtask
    initial begin
        tk(8);
        chk(cal_busy, 1'b1);
        rst = 1'b0;
        t_welcome();
        t_cycle();
        t_menu();
        t_xlong();
        t_led_test();
        conclude();
    end
    initial begin
        #6000000;
        miscompares++;
        conclude();
    end
endmodule // tdmc_tb
